/* File: pkg/osrm_pkg.sv */
package osrm_pkg;

  // ==========================================================================
  // address map
  localparam logic [7:0] OPT_INDEX_ADDR = 8'hFE;
  localparam logic [7:0] OPT_VALUE_ADDR = 8'hFF;
  localparam logic [7:0] BANK_TOP = 8'h1F;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] BIT_AREA_TOP = 8'h2F;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [15:0] XRAM_TOP = 16'h02FF;
  localparam int RAM_DEPTH = 256;

  // ==========================================================================
  // option region indices and values after reset
  localparam logic [7:0] OPT_HRC_IDX = 8'h83;
  localparam logic [7:0] OPT_CTM0_IDX = 8'hC1;
  localparam logic [7:0] OPT_CTM1_IDX = 8'hC2;
  localparam logic [7:0] OPT_INDEX_RST = 8'h00;
  localparam logic [7:0] HRC_RST = 8'h80; // trim at centre frequency
  localparam logic [7:0] CTM0_RST = 8'h00;
  localparam logic [7:0] CTM1_RST = 8'h00;
  localparam logic [7:0] CTM1_MASK = 8'h9C; // bits 6,5,1,0 reserved
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // ==========================================================================
  // one bit per sfr address 80h+i, set where a register exists
  localparam logic [127:0] SFR_MAP =
    128'hF07F_8001_E7FF_FFC0_3F00_FBF7_FCA7_FF8F;

  // ==========================================================================
  // access kinds issued by the core
  typedef enum logic [2:0] {
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_EXTERNAL,
    MODE_BIT,
    MODE_REGOP
  } osrm_mode_t;

  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_IRAM,
    TGT_XRAM,
    TGT_OPIDX,
    TGT_OPVAL,
    TGT_SFR
  } osrm_tgt_t;

  // true where the sfr address has backing storage
  function automatic logic osrm_sfr_assigned(input logic [7:0] addr);
    return SFR_MAP[addr[6:0]];
  endfunction

endpackage

/* File: hdl/osrm_ram.sv */
module osrm_ram import osrm_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);

  logic [7:0] mem [RAM_DEPTH];
  logic [7:0] next_mem [RAM_DEPTH];

  // ==========================================================================
  // byte storage, combinational read
  assign o_rdata = mem[i_addr];

  // next contents: one byte written per cycle
  always_comb begin
    next_mem = mem;
    if (i_we) begin
      next_mem[i_addr] = i_wdata;
    end
  end

  // register the array
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < RAM_DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else begin
      mem <= next_mem;
    end
  end

endmodule

/* File: hdl/osrm_map.sv */
module osrm_map import osrm_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic i_wr,
  input wire osrm_mode_t i_mode,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_bit_wdata,
  input wire logic [1:0] i_bank_sel,
  input wire logic [7:0] i_sfr_rdata,
  output logic o_ack,
  output logic [7:0] o_rdata,
  output logic o_sfr_we,
  output logic [7:0] o_sfr_addr,
  output logic [7:0] o_sfr_wdata,
  output logic [7:0] o_option_index,
  output logic [7:0] o_hrc_trim_option,
  output logic [7:0] o_customer_option_zero,
  output logic [7:0] o_customer_option_one
);

  // ==========================================================================
  // helpers
  function automatic osrm_tgt_t sfr_target(input logic [7:0] addr);
    if (addr == OPT_INDEX_ADDR) begin
      return TGT_OPIDX;
    end else if (addr == OPT_VALUE_ADDR) begin
      return TGT_OPVAL;
    end else if (osrm_sfr_assigned(addr)) begin
      return TGT_SFR;
    end
    return TGT_NONE;
  endfunction

  function automatic logic [7:0] put_bit(input logic [7:0] b,
                                         input logic [2:0] pos,
                                         input logic v);
    logic [7:0] r;
    r = b;
    r[pos] = v;
    return r;
  endfunction

  osrm_tgt_t tgt;
  logic [7:0] byte_addr;
  logic [2:0] bit_pos;
  logic [7:0] iram_rd;
  logic [7:0] xram_rd;
  logic [7:0] opt_rd;
  logic [7:0] cur_byte;
  logic [7:0] wr_byte;
  logic do_wr;
  logic iram_we;
  logic xram_we;
  logic next_ack;
  logic [7:0] next_rdata;
  logic next_sfr_we;
  logic [7:0] next_sfr_addr;
  logic [7:0] next_sfr_wdata;
  logic [7:0] next_option_index;
  logic [7:0] next_hrc;
  logic [7:0] next_ctm0;
  logic [7:0] next_ctm1;

  // ==========================================================================
  // address decode
  always_comb begin
    tgt = TGT_NONE;
    byte_addr = i_addr[7:0];
    bit_pos = 3'd0;
    case (i_mode)
      MODE_DIRECT: begin
        // upper half goes to sfr space, low half to ram
        tgt = i_addr[7] ? sfr_target(i_addr[7:0]) : TGT_IRAM;
      end
      MODE_INDIRECT: begin
        tgt = TGT_IRAM;
      end
      MODE_REGOP: begin
        byte_addr = {3'b000, i_bank_sel, i_addr[2:0]};
        tgt = TGT_IRAM;
      end
      MODE_EXTERNAL: begin
        // storage aliases on the low byte across the printed range
        tgt = (i_addr <= XRAM_TOP) ? TGT_XRAM : TGT_NONE;
      end
      MODE_BIT: begin
        bit_pos = i_addr[2:0];
        if (i_addr[7]) begin
          byte_addr = {i_addr[7:3], 3'b000};
          tgt = sfr_target(byte_addr);
        end else begin
          byte_addr = BIT_AREA_BASE | {4'h0, i_addr[6:3]};
          tgt = TGT_IRAM;
        end
      end
      default: begin
        tgt = TGT_NONE;
      end
    endcase
  end

  // ==========================================================================
  // option value port read selection
  always_comb begin
    case (o_option_index)
      OPT_HRC_IDX: opt_rd = o_hrc_trim_option;
      OPT_CTM0_IDX: opt_rd = o_customer_option_zero;
      OPT_CTM1_IDX: opt_rd = o_customer_option_one & CTM1_MASK;
      default: opt_rd = UNMAPPED_RD;
    endcase
  end

  // current byte at the target, and the byte to write back
  always_comb begin
    case (tgt)
      TGT_IRAM: cur_byte = iram_rd;
      TGT_XRAM: cur_byte = xram_rd;
      TGT_OPIDX: cur_byte = o_option_index;
      TGT_OPVAL: cur_byte = opt_rd;
      TGT_SFR: cur_byte = i_sfr_rdata;
      default: cur_byte = UNMAPPED_RD;
    endcase
    wr_byte = (i_mode == MODE_BIT) ?
              put_bit(cur_byte, bit_pos, i_bit_wdata) : i_wdata;
  end

  assign do_wr = i_req & i_wr;
  assign iram_we = do_wr & (tgt == TGT_IRAM);
  assign xram_we = do_wr & (tgt == TGT_XRAM);

  // ==========================================================================
  // storage for internal and external ram
  osrm_ram u_iram (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_we(iram_we),
    .i_addr(byte_addr),
    .i_wdata(wr_byte),
    .o_rdata(iram_rd)
  );

  osrm_ram u_xram (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_we(xram_we),
    .i_addr(i_addr[7:0]),
    .i_wdata(wr_byte),
    .o_rdata(xram_rd)
  );

  // ==========================================================================
  // next values of registered state
  always_comb begin
    next_ack = i_req;
    next_rdata = o_rdata;
    next_sfr_we = 1'b0;
    next_sfr_addr = o_sfr_addr;
    next_sfr_wdata = o_sfr_wdata;
    next_option_index = o_option_index;
    next_hrc = o_hrc_trim_option;
    next_ctm0 = o_customer_option_zero;
    next_ctm1 = o_customer_option_one;
    if (i_req && !i_wr) begin
      next_rdata = (i_mode == MODE_BIT) ?
                   {7'b000_0000, cur_byte[bit_pos]} : cur_byte;
    end
    if (do_wr) begin
      case (tgt)
        TGT_OPIDX: begin
          next_option_index = wr_byte;
        end
        TGT_OPVAL: begin
          // unknown indices are dropped; software keeps index legal
          case (o_option_index)
            OPT_HRC_IDX: next_hrc = wr_byte;
            OPT_CTM0_IDX: next_ctm0 = wr_byte;
            OPT_CTM1_IDX: next_ctm1 = wr_byte & CTM1_MASK;
            default: next_hrc = o_hrc_trim_option;
          endcase
        end
        TGT_SFR: begin
          next_sfr_we = 1'b1;
          next_sfr_addr = byte_addr;
          next_sfr_wdata = wr_byte;
        end
        default: begin
          next_sfr_we = 1'b0;
        end
      endcase
    end
  end

  // register outputs and option state
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      o_rdata <= 8'h00;
      o_sfr_we <= 1'b0;
      o_sfr_addr <= SFR_BASE;
      o_sfr_wdata <= 8'h00;
      o_option_index <= OPT_INDEX_RST;
      o_hrc_trim_option <= HRC_RST;
      o_customer_option_zero <= CTM0_RST;
      o_customer_option_one <= CTM1_RST;
    end else begin
      o_ack <= next_ack;
      o_rdata <= next_rdata;
      o_sfr_we <= next_sfr_we;
      o_sfr_addr <= next_sfr_addr;
      o_sfr_wdata <= next_sfr_wdata;
      o_option_index <= next_option_index;
      o_hrc_trim_option <= next_hrc;
      o_customer_option_zero <= next_ctm0;
      o_customer_option_one <= next_ctm1;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  logic dir_wr;
  logic dir_rd;
  assign dir_wr = do_wr && (i_mode == MODE_DIRECT);
  assign dir_rd = i_req && !i_wr && (i_mode == MODE_DIRECT);

  index_write_a: assert property (
    dir_wr && i_addr[7:0] == OPT_INDEX_ADDR
    |=> o_option_index == $past(i_wdata))
    else $error("option index not loaded");
  ctm0_write_a: assert property (
    dir_wr && i_addr[7:0] == OPT_VALUE_ADDR && o_option_index == OPT_CTM0_IDX
    |=> o_customer_option_zero == $past(i_wdata))
    else $error("customer option zero not written");
  ctm1_read_a: assert property (
    dir_rd && i_addr[7:0] == OPT_VALUE_ADDR && o_option_index == OPT_CTM1_IDX
    |=> o_ack && o_rdata == (o_customer_option_one & CTM1_MASK))
    else $error("customer option one read wrong");
  index_read_a: assert property (
    dir_rd && i_addr[7:0] == OPT_INDEX_ADDR
    |=> o_rdata == $past(o_option_index))
    else $error("option index read wrong");
  upper_direct_a: assert property (
    i_req && i_mode == MODE_DIRECT && i_addr[7] |-> !iram_we)
    else $error("direct upper access reached ram");
  upper_indirect_a: assert property (
    do_wr && i_mode == MODE_INDIRECT |-> iram_we ##1 !o_sfr_we)
    else $error("indirect access missed ram");
  ext_range_a: assert property (
    do_wr && i_mode == MODE_EXTERNAL && i_addr > XRAM_TOP |-> !xram_we)
    else $error("external write out of range");
  bank_map_a: assert property (
    i_req && i_mode == MODE_REGOP |-> byte_addr <= BANK_TOP && iram_we == i_wr)
    else $error("register operand outside banks");
  bit_area_a: assert property (
    i_req && i_mode == MODE_BIT && !i_addr[7]
    |-> byte_addr >= BIT_AREA_BASE && byte_addr <= BIT_AREA_TOP)
    else $error("bit address outside bit area");
  sfr_bit_a: assert property (
    do_wr && i_mode == MODE_BIT && i_addr[7]
    && osrm_sfr_assigned({i_addr[7:3], 3'b000})
    |=> o_sfr_we && o_sfr_addr[2:0] == 3'd0)
    else $error("bit write to non bit sfr");
  unmapped_a: assert property (
    dir_rd && i_addr[7] && !osrm_sfr_assigned(i_addr[7:0])
    |=> o_ack && o_rdata == UNMAPPED_RD)
    else $error("unassigned sfr read wrong");
  unmapped_wr_a: assert property (
    dir_wr && i_addr[7] && !osrm_sfr_assigned(i_addr[7:0]) |=> !o_sfr_we)
    else $error("unassigned sfr write reached bus");

  opt_seq_c: cover property (
    dir_wr && i_addr[7:0] == OPT_INDEX_ADDR ##1 dir_wr
    && i_addr[7:0] == OPT_VALUE_ADDR);
  bit_sfr_c: cover property (do_wr && i_mode == MODE_BIT && i_addr[7]);
  ext_wr_c: cover property (xram_we);

endmodule

/* File: dv/osrm_sfr_model.sv */
module osrm_sfr_model import osrm_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire osrm_mode_t i_mode,
  input wire logic [15:0] i_addr,
  input wire logic i_we,
  input wire logic [7:0] i_waddr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:127];
  logic [7:0] raddr;

  // ==========================================================================
  // peripheral register storage
  // stores what the map strobes out for assigned registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < 128; k++) begin
        mem[k] <= 8'h00;
      end
    end else if (i_we) begin
      mem[i_waddr[6:0]] <= i_wdata;
    end
  end

  // bit accesses read the whole byte; idle bus shows the inverse
  assign raddr = (i_mode == MODE_BIT) ? {i_addr[7:3], 3'h0} : i_addr[7:0];
  assign o_rdata = i_req ? mem[raddr[6:0]] : ~mem[raddr[6:0]];
endmodule

/* File: dv/testbench.sv */
module testbench import osrm_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, req, wr, bitw, ack, sfr_we, got_we;
  osrm_mode_t mode;
  logic [15:0] addr;
  logic [1:0] bank;
  logic [7:0] wdata, sfr_rd, rdata, sfr_a, sfr_wd, got;
  logic [7:0] opt_i, hrc, ctm0, ctm1;
  int fails, n_checks;

  osrm_map u_osrm_map (.i_sys_clk(clk), .i_rst(rst), .i_req(req),
    .i_wr(wr), .i_mode(mode), .i_addr(addr), .i_wdata(wdata),
    .i_bit_wdata(bitw), .i_bank_sel(bank), .i_sfr_rdata(sfr_rd),
    .o_ack(ack), .o_rdata(rdata), .o_sfr_we(sfr_we),
    .o_sfr_addr(sfr_a), .o_sfr_wdata(sfr_wd), .o_option_index(opt_i),
    .o_hrc_trim_option(hrc), .o_customer_option_zero(ctm0),
    .o_customer_option_one(ctm1));
  osrm_sfr_model u_osrm_sfr_model (.i_sys_clk(clk), .i_rst(rst),
    .i_req(req), .i_mode(mode), .i_addr(addr), .i_we(sfr_we),
    .i_waddr(sfr_a), .i_wdata(sfr_wd), .o_rdata(sfr_rd));

  // ==========================================================================
  // helpers
  function automatic logic [7:0] opt_exp(input logic [7:0] i, v);
    return (i == OPT_CTM1_IDX) ? (v & CTM1_MASK) : v;
  endfunction
  function automatic logic sfr_has(input logic [7:0] a);
    return SFR_MAP[a[6:0]];
  endfunction
  task automatic stop_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one access; results captured in the ack cycle
  task automatic acc(input logic w, input osrm_mode_t m,
                     input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    mode <= m;
    addr <= a;
    wdata <= d;
    bitw <= d[0];
    @(posedge clk);
    req <= 1'b0;
    #1;
    chk({7'h00, ack}, 8'h01);
    got = rdata;
    got_we = sfr_we;
  endtask

  // ==========================================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever begin
      #20 clk = ~clk;
    end
  end
  initial begin
    #(40 * 3000);
    fails++;
    stop_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    logic [7:0] v, a;
    logic [7:0] ix [3];
    logic [7:0] vs [3];
    rst = 1'b1;
    req = 1'b0;
    wr = 1'b0;
    mode = MODE_DIRECT;
    addr = 16'h0000;
    wdata = 8'h00;
    bitw = 1'b0;
    bank = 2'h0;
    void'($urandom(42));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(opt_i, OPT_INDEX_RST);
    chk(hrc, HRC_RST);
    chk(ctm0, CTM0_RST);
    chk(ctm1, CTM1_RST);
    ix = '{OPT_HRC_IDX, OPT_CTM0_IDX, OPT_CTM1_IDX};
    foreach (ix[k]) begin
      vs[k] = 8'($urandom());
      acc(1'b1, MODE_DIRECT, 16'(OPT_INDEX_ADDR), ix[k]);
      chk(opt_i, ix[k]);
      acc(1'b0, MODE_DIRECT, 16'(OPT_INDEX_ADDR), 8'h00);
      chk(got, ix[k]);
      acc(1'b1, MODE_DIRECT, 16'(OPT_VALUE_ADDR), vs[k]);
      acc(1'b0, MODE_DIRECT, 16'(OPT_VALUE_ADDR), 8'h00);
      chk(got, opt_exp(ix[k], vs[k]));
    end
    chk(hrc, vs[0]);
    chk(ctm0, vs[1]);
    chk(ctm1, vs[2] & CTM1_MASK);
    // corner addresses first, then random ones below the option port
    for (int n = 0; n < 22; n++) begin
      a = (n == 0) ? 8'h80 : (n == 1) ? 8'hFD : (n == 2) ? 8'hB0 :
          8'($urandom_range(253, 0));
      v = 8'($urandom());
      acc(1'b1, MODE_INDIRECT, 16'(a), v);
      chk({7'h00, got_we}, 8'h00);
      if (a < SFR_BASE) begin
        acc(1'b0, MODE_DIRECT, 16'(a), 8'h00);
        chk(got, v);
      end else begin
        acc(1'b1, MODE_DIRECT, 16'(a), ~v);
        chk({7'h00, got_we}, {7'h00, sfr_has(a)});
        acc(1'b0, MODE_DIRECT, 16'(a), 8'h00);
        chk(got, sfr_has(a) ? ~v : UNMAPPED_RD);
        acc(1'b0, MODE_INDIRECT, 16'(a), 8'h00);
        chk(got, v);
      end
    end
    for (int b = 0; b < 4; b++) begin
      @(posedge clk);
      bank <= 2'(b);
      v = 8'($urandom());
      acc(1'b1, MODE_REGOP, 16'h0005, v);
      acc(1'b0, MODE_DIRECT, 16'(b * 8 + 5), 8'h00);
      chk(got, v);
    end
    // stack style pushes and pops kept inside e0h-ffh
    for (int s = 0; s < 4; s++) begin
      a = 8'hE0 | 8'($urandom_range(31, 0));
      v = 8'($urandom());
      acc(1'b1, MODE_INDIRECT, 16'(a), v);
      acc(1'b0, MODE_INDIRECT, 16'(a), 8'h00);
      chk(got, v);
    end
    acc(1'b1, MODE_DIRECT, 16'h002F, 8'h00);
    acc(1'b1, MODE_BIT, 16'h007F, 8'h01);
    acc(1'b1, MODE_BIT, 16'h0078, 8'h01);
    acc(1'b0, MODE_DIRECT, 16'h002F, 8'h00);
    chk(got, 8'h81);
    acc(1'b0, MODE_BIT, 16'h0079, 8'h00);
    chk(got, 8'h00);
    acc(1'b1, MODE_DIRECT, 16'h0090, 8'h00);
    acc(1'b1, MODE_BIT, 16'h0093, 8'h01);
    chk(sfr_a, 8'h90);
    chk(sfr_wd, 8'h08);
    acc(1'b1, MODE_BIT, 16'h00B2, 8'h01);
    chk({7'h00, got_we}, 8'h00);
    v = 8'($urandom());
    acc(1'b1, MODE_EXTERNAL, 16'h02FF, v);
    acc(1'b1, MODE_EXTERNAL, 16'h0300, ~v);
    acc(1'b0, MODE_EXTERNAL, 16'h02FF, 8'h00);
    chk(got, v);
    acc(1'b0, MODE_EXTERNAL, 16'h0300, 8'h00);
    chk(got, UNMAPPED_RD);
    stop_test();
  end
endmodule
